//--- hw/bedsr_regs.svh
// Register offsets, field positions and reset values for the bus error/diagnostic block.
// Assumes a 32-bit internal register port addressed by register number.
`ifndef BEDSR_REGS_SVH
`define BEDSR_REGS_SVH

`define BEDSR_ADDR_TIMEOUT   8'h1a
`define BEDSR_ADDR_FAULT     8'h1b
`define BEDSR_ADDR_COMP      8'h1c
`define BEDSR_ADDR_MAINT     8'h1d
`define BEDSR_ADDR_ERROR     8'h1f

// Bus error record fields
`define BEDSR_ERR_CRD_IE     15
`define BEDSR_ERR_CRD        14
`define BEDSR_ERR_RDS        13
`define BEDSR_ERR_CP_TO      12
`define BEDSR_ERR_CP_CNF     8
`define BEDSR_ERR_PF_RDS     7
`define BEDSR_ERR_PF_TO      6
`define BEDSR_ERR_MULTI      2
`define BEDSR_ERR_IDLE       1

// Fault status fields
`define BEDSR_FLT_LATCH      19
`define BEDSR_FLT_IE         18
`define BEDSR_FLT_LINE       17
`define BEDSR_FLT_SLOCK      16
`define BEDSR_FLT_SPARE_MASK 32'h0310_0000

// Comparator fields
`define BEDSR_CMP_LOCK       31
`define BEDSR_CMP_IE         30
`define BEDSR_CMP_UNCOND     29
`define BEDSR_CMP_CODE_LSB   27
`define BEDSR_CMP_CMD_LSB    23
`define BEDSR_CMP_TAG_LSB    20
`define BEDSR_CMP_CNT_LSB    16
`define BEDSR_CMP_RW_MASK    32'h7fff_0000
`define BEDSR_CNT_FULL       4'hf
`define BEDSR_CNT_RESET      4'hf

// Maintenance fields
`define BEDSR_MNT_ID_LSB     23
`define BEDSR_MNT_RW_MASK    32'hffff_f900
`define BEDSR_MNT_MATCH1     10
`define BEDSR_MNT_MATCH0     9

`define BEDSR_TAG_CMD_ADDR   3'h3

`endif

//--- hw/bedsr_pkg.sv
// Types for the bus error/diagnostic block.
// No assumptions beyond SystemVerilog packages.
`default_nettype none
package bedsr_pkg;
	typedef enum logic [1:0] {
		BEDSR_CMP_NONE   = 2'b00,
		BEDSR_CMP_ID     = 2'b01,
		BEDSR_CMP_ID_TAG = 2'b10,
		BEDSR_CMP_ALL    = 2'b11
	} bedsr_code_t;

	// One backplane bus cycle as seen by the comparator
	typedef struct packed {
		logic [4:0]  id;
		logic [2:0]  tag;
		logic [3:0]  mask;
		logic [31:0] data;
	} bedsr_bus_t;

	// One error event from the bus interface
	typedef struct packed {
		logic       timeout;
		logic [1:0] to_type;
		logic       confirm;
		logic       read_data_substitute;
		logic       corrected_read_data;
		logic       prefetch;
	} bedsr_event_t;
endpackage
`default_nettype wire

//--- hw/bedsr_comparator.sv
// Lock counter and compare latch for the history store comparator.
// Assumes the bus cycle and register writes are synchronous to clk.
`include "bedsr_regs.svh"
`default_nettype none
module bedsr_comparator (
	input  wire logic               clk,        // Bus cycle clock
	input  wire logic               sys_rst,    // Async reset, active high
	input  wire bedsr_pkg::bedsr_bus_t bus,     // Sampled bus cycle
	input  wire logic               bus_valid,  // Bus cycle present
	input  wire logic [4:0]         diag_id,    // Diagnostic identifier
	input  wire logic               uncond,     // Unconditional lock mode
	input  wire bedsr_pkg::bedsr_code_t code,   // Conditional compare code
	input  wire logic [3:0]         cmp_cmd,    // Command/mask compare value
	input  wire logic [2:0]         cmp_tag,    // Tag compare value
	input  wire logic               load,       // Count field write
	input  wire logic [3:0]         load_val,   // Written count value
	output logic [3:0]              count,      // Count field
	output logic                    full        // Count reached all ones
);
	import bedsr_pkg::*;

	logic       hit;
	logic       armed;
	logic [3:0] field;

	// Tag selects between command function and mask lines
	assign field = (bus.tag == `BEDSR_TAG_CMD_ADDR) ? bus.data[31:28] : bus.mask;

	always_comb begin
		unique case (code)
			BEDSR_CMP_NONE:   hit = 1'b0;
			BEDSR_CMP_ID:     hit = bus.id == diag_id;
			BEDSR_CMP_ID_TAG: hit = bus.id == diag_id && bus.tag == cmp_tag;
			BEDSR_CMP_ALL:    hit = bus.id == diag_id && bus.tag == cmp_tag && field == cmp_cmd;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			armed <= 1'b0;
		else if (load)
			armed <= 1'b0;
		else if (bus_valid && hit && !uncond)
			armed <= 1'b1;
	end

	assign full = count == `BEDSR_CNT_FULL;

	// One step per bus cycle at most
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			count <= `BEDSR_CNT_RESET;
		else if (load)
			count <= load_val;
		else if (!full && (uncond || armed))
			count <= count + 4'h1;
	end
endmodule
`default_nettype wire

//--- hw/bedsr_top.sv
// Error capture, fault latch, history store lock and maintenance registers of the bus interface.
// Assumes microcode register port with one-cycle write strobe and combinational read data.
//
// Behaviour
// - Writing one to timeout bit clears timeout, type, confirmation and multiple-error bits.
// - Prefetch substitute flag sets on substitute data during prefetch; clears on write or flush.
// - Four prefetch error bits mirror timeout bits for prefetch; clear on write or flush.
// - Prefetch errors go to a microbranch condition, not an interrupt; cycle is read.
// - Multiple-error sets on new timeout or confirmation while one is recorded.
// - Idle bit reads one when the bus interface is not busy.
// - Address latch captures on non-prefetch timeout, holds until timeout bit cleared.
// - Latched word is mode bits, protection flag, then longword address.
// - Fault latch sets on fault rising edge, clears on one; drives fault line.
// - Fault interrupt when fault latch and its enable are set.
// - Status bit shows the live fault line.
// - Fault lock bit sets on fault lock; cleared with fault latch; unlock needs fault low.
// - Simultaneous fault and comparator locks set both lock bits.
// - Unconditional mode counts ones-complement field up to all ones, then locks.
// - Conditional mode latches a compare which enables counting to all ones.
// - Writing count not all ones unlocks, only once fault line is low.
// - Two-bit code selects none, identifier, identifier and tag, or all three.
// - Command/mask compares data bits 31:28 for command tag, else mask lines.
// - Interrupt while comparator lock and its enable are set.
// - Comparator write with count not all ones clears comparator lock.
// - Maintenance holds forcing controls, identifier, parity field; match bits read-only.
// - History store writes and advances each cycle while unlocked: fault low and both lock bits clear.
`include "bedsr_regs.svh"
`default_nettype none
module bedsr_top (
	input  wire logic               clk,            // Bus cycle clock, 100 MHz
	input  wire logic               sys_rst,        // Async reset, active high
	input  wire logic [7:0]         reg_addr,       // Register number
	input  wire logic               reg_wr,         // Write strobe
	input  wire logic [31:0]        reg_wdata,      // Write data
	output logic [31:0]             reg_rdata,      // Read data
	input  wire bedsr_pkg::bedsr_event_t err_ev,    // Error event from bus interface
	input  wire logic [31:0]        req_addr,       // Mode, protect flag, longword address
	input  wire logic               prefetch_flush, // Prefetch buffer flush
	input  wire logic               bus_busy,       // Bus interface busy
	input  wire logic               fault_in,       // Backplane fault line
	output logic                    fault_out,      // Drive fault line
	input  wire bedsr_pkg::bedsr_bus_t bus,         // Sampled bus cycle
	input  wire logic [1:0]         group_match,    // Cache way match status
	output logic                    irq,            // Interrupt request
	output logic                    prefetch_err,   // Prefetch error microbranch
	output logic                    silo_lock,      // History store locked
	output logic                    silo_we,        // History store write
	output logic [3:0]              silo_ptr,       // History store address
	output logic                    silo_first,     // First entry after store unlock
	output logic [31:0]             maint           // Maintenance forcing controls
);
	import bedsr_pkg::*;

	logic        crd_ie, corrected_read_data, read_data_substitute, cp_to, cp_cnf, multi;
	logic [1:0]  cp_type;
	logic        pf_rds, pf_to, pf_cnf;
	logic [1:0]  pf_type;
	logic [31:0] to_addr;
	logic        flt_latch, flt_ie, flt_slock, fault_d;
	logic [2:0]  flt_spare;
	logic        cmp_lock, cmp_ie, cmp_uncond;
	logic [1:0]  cmp_code;
	logic [3:0]  cmp_cmd, cmp_count;
	logic [2:0]  cmp_tag;
	logic        cmp_full;
	logic        fault_prev_low;
	logic [31:0] maint_rw;

	logic wr_err, wr_flt, wr_cmp, wr_mnt;
	logic clr_cp, clr_pf, cp_new, pf_new, fault_rise, cmp_load;

	assign wr_err = reg_wr && reg_addr == `BEDSR_ADDR_ERROR;
	assign wr_flt = reg_wr && reg_addr == `BEDSR_ADDR_FAULT;
	assign wr_cmp = reg_wr && reg_addr == `BEDSR_ADDR_COMP;
	assign wr_mnt = reg_wr && reg_addr == `BEDSR_ADDR_MAINT;

	assign clr_cp = wr_err && reg_wdata[`BEDSR_ERR_CP_TO];
	assign clr_pf = (wr_err && reg_wdata[`BEDSR_ERR_PF_TO]) || prefetch_flush;
	assign cp_new = !err_ev.prefetch && (err_ev.timeout || err_ev.confirm);
	assign pf_new = err_ev.prefetch && (err_ev.timeout || err_ev.confirm);
	assign fault_rise = fault_in && !fault_d;
	assign cmp_load = wr_cmp && reg_wdata[19:16] != `BEDSR_CNT_FULL;

	// Processor-side error bits; a new event wins over a clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cp_to   <= 1'b0;
			cp_type <= 2'b00;
			cp_cnf  <= 1'b0;
			multi   <= 1'b0;
		end else begin
			if (cp_new) begin
				multi <= (cp_to || cp_cnf) || (multi && !clr_cp);
				if (err_ev.timeout) begin
					cp_to   <= 1'b1;
					cp_type <= err_ev.to_type;
				end else if (clr_cp) begin
					cp_to   <= 1'b0;
					cp_type <= 2'b00;
				end
				cp_cnf <= err_ev.confirm || (cp_cnf && !clr_cp);
			end else if (clr_cp) begin
				cp_to   <= 1'b0;
				cp_type <= 2'b00;
				cp_cnf  <= 1'b0;
				multi   <= 1'b0;
			end
		end
	end

	// Prefetch error bits, reported by microbranch only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pf_to   <= 1'b0;
			pf_type <= 2'b00;
			pf_cnf  <= 1'b0;
			pf_rds  <= 1'b0;
		end else begin
			if (pf_new) begin
				pf_to   <= err_ev.timeout || (pf_to && !clr_pf);
				pf_type <= err_ev.timeout ? err_ev.to_type : (clr_pf ? 2'b00 : pf_type);
				pf_cnf  <= err_ev.confirm || (pf_cnf && !clr_pf);
			end else if (clr_pf) begin
				pf_to   <= 1'b0;
				pf_type <= 2'b00;
				pf_cnf  <= 1'b0;
			end
			if (err_ev.read_data_substitute && err_ev.prefetch)
				pf_rds <= 1'b1;
			else if ((wr_err && reg_wdata[`BEDSR_ERR_PF_RDS]) || prefetch_flush)
				pf_rds <= 1'b0;
		end
	end

	assign prefetch_err = pf_to || pf_cnf || pf_rds;

	// Corrected and substitute data flags; clearing while busy is software's care
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			corrected_read_data    <= 1'b0;
			read_data_substitute    <= 1'b0;
			crd_ie <= 1'b0;
		end else begin
			if (err_ev.corrected_read_data && !err_ev.prefetch)
				corrected_read_data <= 1'b1;
			else if (wr_err && reg_wdata[`BEDSR_ERR_CRD])
				corrected_read_data <= 1'b0;
			if (err_ev.read_data_substitute && !err_ev.prefetch)
				read_data_substitute <= 1'b1;
			else if (wr_err && reg_wdata[`BEDSR_ERR_RDS])
				read_data_substitute <= 1'b0;
			if (wr_err)
				crd_ie <= reg_wdata[`BEDSR_ERR_CRD_IE];
		end
	end

	// Timeout address latch; holds the first until released
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			to_addr <= 32'h0000_0000;
		else if (err_ev.timeout && !err_ev.prefetch && (!cp_to || clr_cp))
			to_addr <= req_addr;
	end

	// Fault latch and fault lock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_d   <= 1'b0;
			flt_latch <= 1'b0;
			flt_slock <= 1'b0;
			flt_ie    <= 1'b0;
			flt_spare <= 3'h0;
		end else begin
			fault_d <= fault_in;
			if (fault_rise)
				flt_latch <= 1'b1;
			else if (wr_flt && reg_wdata[`BEDSR_FLT_LATCH])
				flt_latch <= 1'b0;
			if (fault_rise)
				flt_slock <= 1'b1;
			else if (wr_flt && reg_wdata[`BEDSR_FLT_LATCH])
				flt_slock <= 1'b0;
			if (wr_flt) begin
				flt_ie    <= reg_wdata[`BEDSR_FLT_IE];
				flt_spare <= {reg_wdata[25], reg_wdata[24], reg_wdata[20]};
			end
		end
	end

	assign fault_out = flt_latch;

	// Comparator control fields
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_ie     <= 1'b0;
			cmp_uncond <= 1'b0;
			cmp_code   <= 2'b00;
			cmp_cmd    <= 4'h0;
			cmp_tag    <= 3'h0;
		end else if (wr_cmp) begin
			cmp_ie     <= reg_wdata[`BEDSR_CMP_IE];
			cmp_uncond <= reg_wdata[`BEDSR_CMP_UNCOND];
			cmp_code   <= reg_wdata[28:27];
			cmp_cmd    <= reg_wdata[26:23];
			cmp_tag    <= reg_wdata[22:20];
		end
	end

	bedsr_comparator u_cmp (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.bus      (bus),
		.bus_valid(!silo_lock),
		.diag_id  (maint_rw[27:23]),
		.uncond   (cmp_uncond),
		.code     (bedsr_code_t'(cmp_code)),
		.cmp_cmd  (cmp_cmd),
		.cmp_tag  (cmp_tag),
		.load     (wr_cmp),
		.load_val (reg_wdata[19:16]),
		.count    (cmp_count),
		.full     (cmp_full)
	);

	// Comparator lock: armed only when the count is all ones
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			cmp_lock <= 1'b0;
		else if (cmp_full && (cmp_uncond || cmp_code != 2'b00) && !wr_cmp)
			cmp_lock <= 1'b1;
		else if (cmp_load)
			cmp_lock <= 1'b0;
	end

	// Unlock needs both sources released and fault low
	assign silo_lock = fault_in || flt_slock || cmp_lock;

	// History store pointer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			silo_ptr       <= 4'h0;
			fault_prev_low <= 1'b1;
		end else begin
			fault_prev_low <= !silo_lock;
			if (!silo_lock)
				silo_ptr <= silo_ptr + 4'h1;
		end
	end

	assign silo_we    = !silo_lock;
	assign silo_first = !silo_lock && !fault_prev_low;

	// Maintenance register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			maint_rw <= 32'h0000_0000;
		else if (wr_mnt)
			maint_rw <= reg_wdata & `BEDSR_MNT_RW_MASK;
	end

	assign maint = maint_rw;

	assign irq = (flt_latch && flt_ie) || (cmp_lock && cmp_ie)
		|| cp_to || cp_cnf || ((corrected_read_data || read_data_substitute) && crd_ie);

	always_comb begin
		reg_rdata = 32'h0000_0000;
		unique case (reg_addr)
			`BEDSR_ADDR_TIMEOUT: reg_rdata = to_addr;
			`BEDSR_ADDR_FAULT:   reg_rdata = {12'h000, flt_latch, flt_ie, fault_in, flt_slock, 16'h0000}
				| ({6'h00, flt_spare[2:1], 3'h0, flt_spare[0], 20'h00000} & `BEDSR_FLT_SPARE_MASK);
			`BEDSR_ADDR_COMP:    reg_rdata = {cmp_lock, cmp_ie, cmp_uncond, cmp_code, cmp_cmd, cmp_tag,
				cmp_count, 16'h0000};
			`BEDSR_ADDR_MAINT:   reg_rdata = maint_rw | {21'h000000, group_match, 9'h000};
			`BEDSR_ADDR_ERROR:   reg_rdata = {16'h0000, crd_ie, corrected_read_data, read_data_substitute, cp_to, cp_type, 1'b0, cp_cnf,
				pf_rds, pf_to, pf_type, pf_cnf, multi, !bus_busy, 1'b0};
			default:             reg_rdata = 32'h0000_0000;
		endcase
	end
endmodule
`default_nettype wire

//--- sim/bedsr_nexus_model.sv
// Far-side nexus model: random bus cycles and the wired fault line.
// Assumes one bus cycle per clk; the bench picks when a wanted cycle appears.
`default_nettype none
module bedsr_nexus_model (
	input  wire logic                  clk,       // Bus cycle clock
	input  wire logic                  hit,       // Send the wanted cycle
	input  wire bedsr_pkg::bedsr_bus_t want,      // Wanted cycle
	input  wire logic                  fault_req, // Far side pulls fault
	input  wire logic                  fault_drv, // Our side drives fault
	output var bedsr_pkg::bedsr_bus_t  bus,       // Bus cycle seen
	output logic                       fault_in   // Live fault line
);
	timeunit 1ns;
	timeprecision 1ns;
	import bedsr_pkg::*;
	integer      seed = 58;
	logic [31:0] r;
	// Any unit may pull the line, so our own latch keeps it up
	assign fault_in = fault_req | fault_drv;
	initial bus = '0;
	always @(posedge clk) begin
		r = $random(seed);
		// Random traffic never carries the wanted identifier
		bus <= hit ? want : '{id: want.id ^ (r[4:0] | 5'h01), tag: r[7:5], mask: r[11:8], data: $random(seed)};
	end
endmodule
`default_nettype wire

//--- sim/bedsr_top_assertions.sv
// Port checker for the bus error and history lock block.
// Sees only top ports; bound at the foot of this file.
`include "bedsr_regs.svh"
`default_nettype none
module bedsr_top_assertions (
	input wire logic        clk,          // Clock
	input wire logic        sys_rst,      // Reset
	input wire logic [7:0]  reg_addr,     // Register number
	input wire logic        reg_wr,       // Write strobe
	input wire logic [31:0] reg_wdata,    // Write data
	input wire logic [31:0] reg_rdata,    // Read data
	input wire logic        bus_busy,     // Busy
	input wire logic        fault_in,     // Fault line
	input wire logic        fault_out,    // Fault drive
	input wire logic        prefetch_err, // Prefetch branch
	input wire logic        silo_lock,    // Locked
	input wire logic        silo_we,      // Store write
	input wire logic [3:0]  silo_ptr      // Store address
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_latch; $rose(fault_in) |=> fault_out; endproperty
	a_latch: assert property (p_latch) else $error("fault latch missed edge");
	property p_latch_rd; reg_addr == `BEDSR_ADDR_FAULT |-> reg_rdata[19] == fault_out; endproperty
	a_latch_rd: assert property (p_latch_rd) else $error("fault latch read differs");
	property p_idle;
		reg_addr == `BEDSR_ADDR_ERROR && $stable(bus_busy) && !$past(sys_rst) |-> reg_rdata[1] == !bus_busy;
	endproperty
	a_idle: assert property (p_idle) else $error("idle bit wrong");
	property p_pf; reg_addr == `BEDSR_ADDR_ERROR && reg_rdata[6] |-> prefetch_err; endproperty
	a_pf: assert property (p_pf) else $error("prefetch branch missing");
	property p_we; silo_we == !silo_lock; endproperty
	a_we: assert property (p_we) else $error("store write while locked");
	property p_ptr; silo_we |=> silo_ptr == $past(silo_ptr) + 4'h1; endproperty
	a_ptr: assert property (p_ptr) else $error("store address did not advance");
	property p_hold; silo_lock |=> $stable(silo_ptr); endproperty
	a_hold: assert property (p_hold) else $error("store address moved while locked");
	property p_flock; $rose(fault_in) |-> ##[0:1] silo_lock; endproperty
	a_flock: assert property (p_flock) else $error("fault did not lock store");
	property p_unc;
		reg_wr && reg_addr == `BEDSR_ADDR_COMP && reg_wdata[29] && reg_wdata[19:16] == 4'he && !silo_lock && !fault_in
			|=> !silo_lock ##1 !silo_lock ##1 silo_lock;
	endproperty
	a_unc: assert property (p_unc) else $error("unconditional lock timing");
	c_lock: cover property ($rose(silo_lock));
	c_fault: cover property ($rose(fault_out));
	c_pf: cover property ($rose(prefetch_err));
endmodule
bind bedsr_top bedsr_top_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_busy(bus_busy), .fault_in(fault_in), .fault_out(fault_out),
	.prefetch_err(prefetch_err), .silo_lock(silo_lock), .silo_we(silo_we), .silo_ptr(silo_ptr));
`default_nettype wire

//--- sim/bedsr_top_bench.sv
// Self-checking bench for the bus error and history lock block.
// Drives register port and error events; the nexus model drives bus and fault.
`include "bedsr_regs.svh"
`default_nettype none
module bedsr_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import bedsr_pkg::*;
	logic         clk = 1'h0, sys_rst = 1'h1, wr_en = 1'h0, flush = 1'h0, busy = 1'h0, hit = 1'h0, freq = 1'h0;
	logic [1:0]   gm = 2'h0, cd;
	logic [3:0]   cm, ptr, vals [4];
	logic [4:0]   mid;
	logic [7:0]   addr = 8'h00;
	logic [31:0]  wdata = 32'h0, raddr = 32'h0, rdata, maint, rd, a, w;
	bedsr_event_t ev = '0;
	bedsr_bus_t   want = '0, bus;
	logic         fin, fout, irq, pf_err, lock, we, first;
	integer       seed = 58, fail_count = 0, check_count = 0, cycles = 0, n;

	bedsr_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wr(wr_en), .reg_wdata(wdata), .reg_rdata(rdata),
		.err_ev(ev), .req_addr(raddr), .prefetch_flush(flush), .bus_busy(busy), .fault_in(fin), .fault_out(fout),
		.bus(bus), .group_match(gm), .irq(irq), .prefetch_err(pf_err), .silo_lock(lock), .silo_we(we),
		.silo_ptr(ptr), .silo_first(first), .maint(maint));
	bedsr_nexus_model far (.clk(clk), .hit(hit), .want(want), .fault_req(freq), .fault_drv(fout), .bus(bus),
		.fault_in(fin));

	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	function automatic logic [31:0] cp_word(logic [1:0] ty, logic m);
		return m ? (32'h1106 | {20'h0, ty, 10'h0}) : 32'h2;
	endfunction
	function automatic logic [31:0] lock_wait(logic [3:0] v);
		return (v == 4'hf) ? 32'h0 : 32'h10 - {28'h0, v};
	endfunction
	function automatic bedsr_bus_t mk(int k, logic swap);
		logic s;
		s = (k == 2) ^ swap;
		return '{id: mid, tag: (k == 2) ? `BEDSR_TAG_CMD_ADDR : 3'h5, mask: s ? ~cm : cm, data: {s ? cm : ~cm, 28'h0}};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t %s seen %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask
	task automatic rdr(input logic [7:0] ad);
		@(posedge clk);
		addr <= ad;
		#1 rd = rdata;
	endtask
	task automatic pulse(input bedsr_event_t e);
		@(posedge clk) ev <= e;
		@(posedge clk) ev <= '0;
	endtask
	// Bounded wait; leaves the number of edges in n
	task automatic wait_lock(input logic v, input int lim);
		n = 0;
		while (lock !== v && n < lim) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'h0;
		rdr(8'h10);
		check(rd, 32'h0, "unmapped read");
		a = $random(seed);
		a[28] = 1'h0;
		raddr <= a;
		pulse(7'h60);
		raddr <= ~a;
		pulse(7'h08);
		rdr(`BEDSR_ADDR_ERROR);
		check(rd, cp_word(2'h2, 1'h1), "error record");
		rdr(`BEDSR_ADDR_TIMEOUT);
		check(rd, a, "timeout address");
		wr(`BEDSR_ADDR_ERROR, 32'h1000);
		rdr(`BEDSR_ADDR_ERROR);
		check(rd, cp_word(2'h0, 1'h0), "record cleared");
		pulse(7'h59);
		rdr(`BEDSR_ADDR_TIMEOUT);
		check(rd, a, "no prefetch capture");
		rdr(`BEDSR_ADDR_ERROR);
		check(rd, 32'h5a, "prefetch bits");
		check(32'(pf_err), 32'h1, "prefetch branch");
		check(32'(irq), 32'h0, "no prefetch irq");
		pulse(7'h05);
		wr(`BEDSR_ADDR_ERROR, 32'h40);
		rdr(`BEDSR_ADDR_ERROR);
		check(rd, 32'h82, "substitute kept");
		@(posedge clk) flush <= 1'h1;
		@(posedge clk) flush <= 1'h0;
		rdr(`BEDSR_ADDR_ERROR);
		check(rd, 32'h2, "flushed");
		pulse(7'h04);
		wr(`BEDSR_ADDR_ERROR, 32'h2000);
		rdr(`BEDSR_ADDR_ERROR);
		check(rd, 32'h2, "substitute cleared");
		repeat (8) begin
			@(posedge clk) busy <= 1'($random(seed));
			rdr(`BEDSR_ADDR_ERROR);
			check(32'(rd[1]), 32'(!busy), "idle bit");
		end
		busy <= 1'h0;
		w = $random(seed);
		gm <= 2'($random(seed));
		wr(`BEDSR_ADDR_MAINT, w);
		rdr(`BEDSR_ADDR_MAINT);
		check(rd, (w & `BEDSR_MNT_RW_MASK) | {21'h0, gm, 9'h0}, "maintenance");
		check(maint, w & `BEDSR_MNT_RW_MASK, "forcing outputs");
		mid = w[27:23];
		wr(`BEDSR_ADDR_FAULT, 32'h0314_0000);
		@(posedge clk) freq <= 1'h1;
		@(posedge clk) freq <= 1'h0;
		rdr(`BEDSR_ADDR_FAULT);
		check(rd, 32'h031f_0000, "fault latched");
		check(32'(irq), 32'h1, "fault irq");
		check(32'(lock), 32'h1, "fault lock");
		wr(`BEDSR_ADDR_FAULT, 32'h031c_0000);
		#1 check(32'(first), 32'h1, "first entry after unlock");
		wait_lock(1'h0, 4);
		rdr(`BEDSR_ADDR_FAULT);
		check(rd, 32'h0314_0000, "fault cleared");
		check(32'(lock), 32'h0, "fault unlock");
		check(32'(first), 32'h0, "first entry only once");
		wr(`BEDSR_ADDR_FAULT, 32'h0);
		vals = '{4'he, 4'h9, 4'h0, 4'($random(seed))};
		foreach (vals[i]) begin
			wr(`BEDSR_ADDR_COMP, 32'h6000_0000 | {12'h0, vals[i], 16'h0});
			#1 wait_lock(1'h1, 20);
			check(32'(n), lock_wait(vals[i]), "lock delay");
			rdr(`BEDSR_ADDR_COMP);
			check(rd, 32'he00f_0000, "comparator locked");
			check(32'(irq), 32'h1, "lock irq");
		end
		wr(`BEDSR_ADDR_COMP, 32'h0);
		cm = 4'($random(seed));
		for (int k = 0; k < 4; k++) begin
			cd = (k < 2) ? 2'(k + 1) : 2'h3;
			want <= mk(k, 1'h0);
			wr(`BEDSR_ADDR_COMP, {3'h0, cd, cm, (k == 2) ? `BEDSR_TAG_CMD_ADDR : 3'h5, 4'he, 16'h0});
			wait_lock(1'h1, 6);
			check(32'(lock), 32'h0, "no compare");
			if (k >= 2) begin
				want <= mk(k, 1'h1);
				hit <= 1'h1;
				wait_lock(1'h1, 6);
				check(32'(lock), 32'h0, "wrong field");
			end
			want <= mk(k, 1'h0);
			hit <= 1'h1;
			wait_lock(1'h1, 10);
			check(32'(lock), 32'h1, "compare lock");
			hit <= 1'h0;
			wr(`BEDSR_ADDR_COMP, 32'h0);
		end
		hit <= 1'h1;
		wr(`BEDSR_ADDR_COMP, 32'h000e_0000);
		wait_lock(1'h1, 8);
		check(32'(lock), 32'h0, "code none");
		wrap_up();
	end
endmodule
`default_nettype wire
